// *** core/psf_framer.sv ***
// Result image framer with AXI4-Lite register access
//
// Summary of operation
// (R1) Only one layout, measurement or teach, is shown; the other reads zero.
// (R2) Bytes 1 to 16 hold the measurement result layout.
// (R3) Measurement status: bit 1 mismatch, bits 5:4 device address, bit 7 zero.
// (R4) Status bit 0 shows system fault, or evaluation fault in the measurement layout and teach fault in the teach layout.
// (R5) Status bit 3 event and bit 2 warning always read zero.
// (R6) Byte 2 holds matched profile 1 to 32, zero when nothing found.
// (R7) Byte 3 counter counts evaluations and restarts after 0x3F.
// (R8) Bytes 4 to 6 hold goodness, variation, outliers quality, 0 to 100.
// (R9) Bytes 7 and 8 hold 14-bit X deviation, upper seven bits first.
// (R10) Bytes 9 and 10 hold 14-bit Z deviation, upper seven bits first.
// (R11) Bytes 17 to 24 hold the teach result layout.
// (R12) Teach status: bit 1 and event bit 3 zero; address, fault as before.
// (R13) Byte 19 teach counter counts every teach-in.
// (R14) Byte 20 holds teach quality 0 to 100; bytes 21 to 23 zero.
// (R15) Teach result byte 18 and measurement bytes 12 to 16 read zero.
// (R16) Checksum is XOR of preceding layout bytes, bit 7 zero.
// (R17) All fields of the active layout refresh in the same cycle.
// (R18) Master pulses trigger bit to start one capture.
// (R19) Master sets teach bit, then triggers, and clears it before repeating.
`timescale 1ns/1ps
`default_nettype none

module psf_framer
  import psf_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  // Evaluation results, one pulse per finished evaluation
  input wire logic evalDone,
  input wire logic evalFault,
  input wire logic evalNoMatch,
  input wire logic [6:0] evalProfile,
  input wire logic [6:0] evalQualGood,
  input wire logic [6:0] evalQualVar,
  input wire logic [6:0] evalQualOut,
  input wire logic [13:0] evalXDev,
  input wire logic [13:0] evalZDev,
  // Teach results, one pulse per finished teach-in
  input wire logic teachDone,
  input wire logic teachFault,
  input wire logic [6:0] teachQuality,
  // Live system fault level
  input wire logic sysFault,
  // Input image toward the fieldbus master
  output logic [8*psf_pkg::IMG_BYTES-1:0] frameImage_ff,
  output logic teachActive_ff,
  output logic irq_ff,
  // AXI4-Lite slave
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  import psf_pkg::*;

  // ==========================================================================
  // Stored result fields
  logic evalFault_ff;
  logic noMatch_ff;
  logic [6:0] profile_ff;
  logic [6:0] evalCount_ff;
  logic [6:0] qualGood_ff;
  logic [6:0] qualVar_ff;
  logic [6:0] qualOut_ff;
  logic [13:0] xDev_ff;
  logic [13:0] zDev_ff;
  logic teachFault_ff;
  logic [6:0] teachCount_ff;
  logic [6:0] teachQual_ff;
  logic [1:0] devAddr_ff;
  logic [EV_W-1:0] evStat_ff;
  logic [EV_W-1:0] evMask_ff;
  logic sysFaultDly_ff;

  // Quality above the scale is held at the top of the scale
  function automatic logic [6:0] clampQual(input logic [6:0] q);
    clampQual = (q > QUAL_MAX) ? QUAL_MAX : q;
  endfunction : clampQual

  // Evaluation fields: every field loads on the same done pulse
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      evalFault_ff <= 1'b0;
      noMatch_ff <= 1'b0;
      profile_ff <= 7'h00;
      qualGood_ff <= 7'h00;
      qualVar_ff <= 7'h00;
      qualOut_ff <= 7'h00;
      xDev_ff <= 14'h0000;
      zDev_ff <= 14'h0000;
    end else if (evalDone) begin // see (R17)
      evalFault_ff <= evalFault;
      noMatch_ff <= evalNoMatch;
      profile_ff <= (evalProfile > PROF_MAX) ? 7'h00 : evalProfile; // see (R6)
      qualGood_ff <= clampQual(evalQualGood); // see (R8)
      qualVar_ff <= clampQual(evalQualVar);
      qualOut_ff <= clampQual(evalQualOut);
      xDev_ff <= evalXDev; // see (R9)
      zDev_ff <= evalZDev; // see (R10)
    end
  end

  // Evaluation counter restarts after its wrap value
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      evalCount_ff <= 7'h00;
    end else if (evalDone) begin
      evalCount_ff <= (evalCount_ff >= COUNT_WRAP) ? 7'h00
                      : evalCount_ff + 7'h01; // see (R7)
    end
  end

  // Teach fields and counter
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      teachFault_ff <= 1'b0;
      teachQual_ff <= 7'h00;
      teachCount_ff <= 7'h00;
    end else if (teachDone) begin
      teachFault_ff <= teachFault;
      teachQual_ff <= clampQual(teachQuality); // see (R14)
      teachCount_ff <= teachCount_ff + 7'h01; // see (R13)
    end
  end

  // Layout select: a teach result shows until the next evaluation
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      teachActive_ff <= 1'b0;
    end else if (teachDone) begin
      teachActive_ff <= 1'b1; // see (R1)
    end else if (evalDone) begin
      teachActive_ff <= 1'b0;
    end
  end

  // ==========================================================================
  // Image assembly
  logic [7:0] measStatus;
  logic [7:0] teachStatus;
  logic [8*IMG_BYTES-1:0] nxt_frameImage;

  // Status bytes; event, warning and bit 7 stay zero
  always_comb begin
    measStatus = 8'h00; // see (R5)
    measStatus[ST_FAULT] = sysFault | evalFault_ff; // see (R4)
    measStatus[ST_NOMATCH] = noMatch_ff; // see (R3)
    measStatus[ST_ADDR_LSB+:2] = devAddr_ff;
    teachStatus = 8'h00; // see (R12)
    teachStatus[ST_FAULT] = sysFault | teachFault_ff; // see (R4)
    teachStatus[ST_ADDR_LSB+:2] = devAddr_ff;
  end

  // Whole image built at once; inactive layout and spare bytes stay zero
  always_comb begin
    logic [7:0] sum;
    sum = 8'h00;
    nxt_frameImage = '0; // see (R15)
    if (!teachActive_ff) begin // see (R1)
      nxt_frameImage[8*0+:8] = measStatus; // see (R2)
      nxt_frameImage[8*1+:8] = {1'b0, profile_ff};
      nxt_frameImage[8*2+:8] = {1'b0, evalCount_ff};
      nxt_frameImage[8*3+:8] = {1'b0, qualGood_ff};
      nxt_frameImage[8*4+:8] = {1'b0, qualVar_ff};
      nxt_frameImage[8*5+:8] = {1'b0, qualOut_ff};
      nxt_frameImage[8*6+:8] = {1'b0, xDev_ff[13:7]}; // see (R9)
      nxt_frameImage[8*7+:8] = {1'b0, xDev_ff[6:0]};
      nxt_frameImage[8*8+:8] = {1'b0, zDev_ff[13:7]}; // see (R10)
      nxt_frameImage[8*9+:8] = {1'b0, zDev_ff[6:0]};
      for (int i = MEAS_FIRST; i < MEAS_SUM; i++) begin
        sum = sum ^ nxt_frameImage[8*(i-1)+:8];
      end
      nxt_frameImage[8*(MEAS_SUM-1)+:8] = {1'b0, sum[6:0]}; // see (R16)
    end else begin
      nxt_frameImage[8*16+:8] = teachStatus; // see (R11)
      nxt_frameImage[8*18+:8] = {1'b0, teachCount_ff}; // see (R13)
      nxt_frameImage[8*19+:8] = {1'b0, teachQual_ff}; // see (R14)
      for (int i = TEACH_FIRST; i < TEACH_SUM; i++) begin
        sum = sum ^ nxt_frameImage[8*(i-1)+:8];
      end
      nxt_frameImage[8*(TEACH_SUM-1)+:8] = {1'b0, sum[6:0]}; // see (R16)
    end
  end

  // Single register stage so the master never sees a half update
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      frameImage_ff <= '0;
    end else begin
      frameImage_ff <= nxt_frameImage; // see (R17)
    end
  end

  // ==========================================================================
  // AXI4-Lite write channel
  logic awHeld_ff;
  logic wHeld_ff;
  logic [7:0] awAddr_ff;
  logic [31:0] wData_ff;
  logic wLane0_ff;
  logic awTake;
  logic wTake;
  logic doWrite;
  logic nxt_awHeld;
  logic nxt_wHeld;
  logic nxt_bvalid;

  assign awTake = s_axi_awvalid & s_axi_awready;
  assign wTake = s_axi_wvalid & s_axi_wready;
  assign doWrite = awHeld_ff & wHeld_ff & ~s_axi_bvalid;
  assign nxt_awHeld = doWrite ? 1'b0 : (awHeld_ff | awTake);
  assign nxt_wHeld = doWrite ? 1'b0 : (wHeld_ff | wTake);
  assign nxt_bvalid = doWrite | (s_axi_bvalid & ~s_axi_bready);

  // Address and data may arrive in either order; both wait for the other
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      awHeld_ff <= 1'b0;
      wHeld_ff <= 1'b0;
      awAddr_ff <= 8'h00;
      wData_ff <= 32'h0000_0000;
      wLane0_ff <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else begin
      awHeld_ff <= nxt_awHeld;
      wHeld_ff <= nxt_wHeld;
      if (awTake) begin
        awAddr_ff <= s_axi_awaddr;
      end
      if (wTake) begin
        wData_ff <= s_axi_wdata;
        wLane0_ff <= s_axi_wstrb[0];
      end
      // Ready drops while a word is parked or a response is pending
      s_axi_awready <= ~nxt_awHeld & ~nxt_bvalid;
      s_axi_wready <= ~nxt_wHeld & ~nxt_bvalid;
      s_axi_bvalid <= nxt_bvalid;
      if (doWrite) begin
        s_axi_bresp <= (awAddr_ff == CTRL_OFS || awAddr_ff == STAT_OFS
                        || awAddr_ff == MASK_OFS) ? RESP_OKAY : RESP_SLVERR;
      end
    end
  end

  logic regWrite;
  assign regWrite = doWrite & wLane0_ff;

  // Control and mask registers; all fields live in byte lane 0
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      devAddr_ff <= CTRL_ADDR_RST;
      evMask_ff <= EV_RST;
    end else if (regWrite) begin
      if (awAddr_ff == CTRL_OFS) begin
        devAddr_ff <= wData_ff[CTRL_ADDR_LSB+:2]; // see (R3)
      end
      if (awAddr_ff == MASK_OFS) begin
        evMask_ff <= wData_ff[EV_W-1:0];
      end
    end
  end

  // ==========================================================================
  // Sticky events; a new event in the clearing cycle survives the clear
  logic [EV_W-1:0] evSet;
  logic [EV_W-1:0] evClr;

  always_comb begin
    evSet = '0;
    evSet[EV_EVAL] = evalDone;
    evSet[EV_TEACH] = teachDone;
    evSet[EV_FAULT] = (sysFault & ~sysFaultDly_ff)
                      | (evalDone & evalFault) | (teachDone & teachFault);
    evClr = (regWrite && awAddr_ff == STAT_OFS) ? wData_ff[EV_W-1:0] : '0;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sysFaultDly_ff <= 1'b0;
      evStat_ff <= EV_RST;
      irq_ff <= 1'b0;
    end else begin
      sysFaultDly_ff <= sysFault;
      evStat_ff <= (evStat_ff & ~evClr) | evSet;
      irq_ff <= |(((evStat_ff & ~evClr) | evSet) & evMask_ff);
    end
  end

  // ==========================================================================
  // AXI4-Lite read channel; one read at a time, answer one cycle after take
  logic arTake;
  logic [31:0] rdMux;
  logic rdHit;

  assign arTake = s_axi_arvalid & s_axi_arready;

  // Image words pack four bytes, byte 1 of the image in the low lane
  always_comb begin
    rdMux = 32'h0000_0000;
    rdHit = 1'b1;
    if (s_axi_araddr == CTRL_OFS) begin
      rdMux[CTRL_ADDR_LSB+:2] = devAddr_ff;
    end else if (s_axi_araddr == STAT_OFS) begin
      rdMux[EV_W-1:0] = evStat_ff;
    end else if (s_axi_araddr == MASK_OFS) begin
      rdMux[EV_W-1:0] = evMask_ff;
    end else if (s_axi_araddr >= IMG_OFS && s_axi_araddr < IMG_END
                 && s_axi_araddr[1:0] == 2'b00) begin
      rdMux = frameImage_ff[32*((s_axi_araddr - IMG_OFS) >> 2)+:32];
    end else begin
      rdHit = 1'b0;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= RESP_OKAY;
    end else begin
      if (arTake) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rdMux;
        s_axi_rresp <= rdHit ? RESP_OKAY : RESP_SLVERR;
        s_axi_arready <= 1'b0;
      end else if (s_axi_rvalid & s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end else begin
        s_axi_arready <= ~s_axi_rvalid;
      end
    end
  end

endmodule : psf_framer

`default_nettype wire

// *** core/psf_pkg.sv ***
// Constants shared by the profile sensor result framer
package psf_pkg;
  // ==========================================================================
  // Register map (byte addresses)
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] STAT_OFS = 8'h04;
  localparam logic [7:0] MASK_OFS = 8'h08;
  localparam logic [7:0] IMG_OFS = 8'h10;
  localparam int IMG_WORDS = 6;
  localparam logic [7:0] IMG_END = 8'h28;

  // ==========================================================================
  // Control register fields
  localparam int CTRL_ADDR_LSB = 0;
  localparam logic [1:0] CTRL_ADDR_RST = 2'h0;

  // ==========================================================================
  // Event bits, shared by status and mask
  localparam int EV_EVAL = 0;
  localparam int EV_TEACH = 1;
  localparam int EV_FAULT = 2;
  localparam int EV_W = 3;
  localparam logic [2:0] EV_RST = 3'h0;

  // ==========================================================================
  // Image layout: byte n of the image sits at bits 8*(n-1)
  localparam int IMG_BYTES = 24;
  localparam int MEAS_FIRST = 1;
  localparam int MEAS_SUM = 11;
  localparam int TEACH_FIRST = 17;
  localparam int TEACH_SUM = 24;
  localparam int ST_FAULT = 0;
  localparam int ST_NOMATCH = 1;
  localparam int ST_ADDR_LSB = 4;

  // ==========================================================================
  // Field limits
  localparam logic [6:0] COUNT_WRAP = 7'h3F;
  localparam logic [6:0] QUAL_MAX = 7'h64;
  localparam logic [6:0] PROF_MAX = 7'h20;

  // ==========================================================================
  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage : psf_pkg

// *** dv/psf_bus_reader.sv ***
// Fieldbus master stand-in that polls the input image cyclically
`timescale 1ns/1ps
`default_nettype none
module psf_bus_reader #(
  parameter int POLL = 4
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [8*psf_pkg::IMG_BYTES-1:0] frameImage_ff,
  output logic [8*psf_pkg::IMG_BYTES-1:0] snapImage_ff
);
  import psf_pkg::*;
  int pollCnt_ff;
  // ==========================================================================
  // Poll; the master only ever copies a whole image at once
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pollCnt_ff <= 0;
      snapImage_ff <= '0;
    end else begin
      pollCnt_ff <= (pollCnt_ff == POLL - 1) ? 0 : pollCnt_ff + 1;
      if (pollCnt_ff == 0) snapImage_ff <= frameImage_ff;
    end
  end
endmodule : psf_bus_reader
`default_nettype wire

// *** dv/psf_framer_assertions.sv ***
// Concurrent checks on the framer's input image
`timescale 1ns/1ps
`default_nettype none
module psf_framer_assertions (
  input wire logic clk,
  input wire logic rst,
  input wire logic evalDone,
  input wire logic teachDone,
  input wire logic [6:0] evalProfile,
  input wire logic [13:0] evalXDev,
  input wire logic [8*psf_pkg::IMG_BYTES-1:0] frameImage_ff,
  input wire logic teachActive_ff
);
  import psf_pkg::*;
  logic [7:0] mSum;
  logic [7:0] tSum;
  // ==========================================================================
  // Checksums rebuilt from the image; an idle layout sums to zero too
  always_comb begin
    mSum = 8'h00;
    tSum = 8'h00;
    for (int i = 0; i < 10; i++) begin
      mSum = mSum ^ frameImage_ff[8*i +: 8];
    end
    for (int i = 16; i < 23; i++) begin
      tSum = tSum ^ frameImage_ff[8*i +: 8];
    end
  end
  // ==========================================================================
  // Single domain, so shared clocking and reset
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // A lone evaluation pulse followed by one quiet cycle; a teach pulse followed by a cycle without evaluation
  sequence evalOnly;
    evalDone && !teachDone ##1 !(evalDone || teachDone);
  endsequence
  sequence teachOnly;
    teachDone ##1 !evalDone;
  endsequence
  AST_ONE_LAYOUT: assert property (
    frameImage_ff[127:0] == '0 || frameImage_ff[191:128] == '0)
    else $error("both layouts shown");
  AST_STATUS_BITS: assert property (
    frameImage_ff[7] == 1'h0 && frameImage_ff[3:2] == 2'h0 &&
    frameImage_ff[135] == 1'h0 && frameImage_ff[131:129] == 3'h0)
    else $error("status spare bit set");
  AST_ZERO_BYTES: assert property (
    frameImage_ff[127:88] == '0 && frameImage_ff[143:136] == '0 &&
    frameImage_ff[183:160] == '0)
    else $error("unused byte set");
  AST_MEAS_SUM: assert property (
    frameImage_ff[87:80] == {1'h0, mSum[6:0]})
    else $error("measurement checksum wrong");
  AST_TEACH_SUM: assert property (
    frameImage_ff[191:184] == {1'h0, tSum[6:0]})
    else $error("teach checksum wrong");
  AST_EVAL_LAYOUT: assert property (evalOnly |=> !teachActive_ff)
    else $error("measurement layout not shown");
  AST_TEACH_LAYOUT: assert property (teachOnly |=> teachActive_ff)
    else $error("teach layout not shown");
  AST_PROFILE: assert property (evalOnly |=> frameImage_ff[15:8] ==
    (($past(evalProfile, 2) > PROF_MAX) ? 8'h00 : {1'h0, $past(evalProfile, 2)}))
    else $error("profile byte wrong");
  AST_X_DEV: assert property (evalOnly |=>
    frameImage_ff[54:48] == $past(evalXDev[13:7], 2) &&
    frameImage_ff[62:56] == $past(evalXDev[6:0], 2))
    else $error("x deviation bytes wrong");
endmodule : psf_framer_assertions
bind psf_framer psf_framer_assertions u_chk (.clk, .rst, .evalDone,
  .teachDone, .evalProfile, .evalXDev, .frameImage_ff, .teachActive_ff);
`default_nettype wire

// *** dv/tb_top.sv ***
// Self-checking bench for the result framer
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import psf_pkg::*;
  logic clk, rst, evalDone, evalFault, evalNoMatch, teachDone, teachFault;
  logic sysFault, teachActive_ff, irq_ff, tShow;
  logic [6:0] evalProfile, evalQualGood, evalQualVar, evalQualOut;
  logic [6:0] teachQuality, eCnt, tCnt;
  logic [13:0] evalXDev, evalZDev;
  logic [191:0] frameImage_ff, snapImage_ff;
  logic [7:0] s_axi_awaddr, s_axi_araddr, expB [1:24];
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic s_axi_rvalid, s_axi_rready;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, devAddr;
  int errors, checks, seed;
  psf_framer u_dut (.clk, .rst, .evalDone, .evalFault, .evalNoMatch,
    .evalProfile, .evalQualGood, .evalQualVar, .evalQualOut, .evalXDev,
    .evalZDev, .teachDone, .teachFault, .teachQuality, .sysFault,
    .frameImage_ff, .teachActive_ff, .irq_ff, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready);
  psf_bus_reader #(.POLL(4)) u_rdr (.clk, .rst, .frameImage_ff,
    .snapImage_ff);
  // ==========================================================================
  // Clock, verdict and compare
  initial begin
    clk = 1'h0;
    forever #50 clk = ~clk;
  end
  task automatic close_out();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : close_out
  task automatic chk(input logic [191:0] got, input logic [191:0] exp);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("mismatch at %0t: got %h exp %h", $time, got, exp);
    end
  endtask : chk
  // Expected image: only the active layout, the other reads zero
  function automatic logic [191:0] img();
    logic [191:0] r;
    r = '0;
    for (int n = 1; n <= 24; n++) begin
      if ((n > 16) == tShow) r[8*n-8 +: 8] = expB[n];
    end
    return r;
  endfunction : img
  function automatic logic [7:0] cq(input logic [6:0] v);
    return (v > QUAL_MAX) ? {1'h0, QUAL_MAX} : {1'h0, v};
  endfunction : cq
  // ==========================================================================
  // Register bus cycles; each wait bounded, a hang ends the run
  task automatic axw(input logic [7:0] a, input logic [31:0] d,
      input logic [1:0] er);
    int n;
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'h1;
    s_axi_wdata <= d;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    for (n = 0; n < 40 && !s_axi_bvalid; n++) begin
      @(posedge clk);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
    end
    s_axi_bready <= 1'h0;
    // A write that never answers counts against the run
    if (n == 40) begin
      errors++;
      $display("mismatch at %0t: write answer timed out", $time);
      close_out();
    end
    chk(192'(s_axi_bresp), 192'(er));
  endtask : axw
  task automatic axr(input logic [7:0] a, output logic [31:0] d,
      input logic [1:0] er);
    int n;
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    for (n = 0; n < 40 && !s_axi_rvalid; n++) begin
      @(posedge clk);
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
    end
    s_axi_rready <= 1'h0;
    d = s_axi_rdata;
    if (n == 40) begin
      errors++;
      $display("mismatch at %0t: read answer timed out", $time);
      close_out();
    end
    chk(192'(s_axi_rresp), 192'(er));
  endtask : axr
  // One result pulse with random fields, then the whole image compared
  task automatic fire(input logic tch, input logic [6:0] p,
      input logic [6:0] q);
    logic [6:0] v, o;
    logic [13:0] x, z;
    logic [2:0] f;
    int s;
    logic [7:0] b [11];
    v = $random(seed);
    o = $random(seed);
    x = $random(seed);
    z = $random(seed);
    f = $random(seed);
    @(posedge clk);
    {evalDone, teachDone} <= {!tch, tch};
    // Result faults share f[2]; the live system fault is f[0]
    {evalFault, teachFault, evalNoMatch, sysFault} <= {f[2], f};
    {evalProfile, evalQualGood, teachQuality} <= {p, q, q};
    {evalQualVar, evalQualOut, evalXDev, evalZDev} <= {v, o, x, z};
    @(posedge clk);
    {evalDone, teachDone} <= 2'h0;
    tShow = tch;
    s = tch ? 24 : 11;
    if (tch) begin
      tCnt = tCnt + 7'h1;
      b = '{{2'h0, devAddr, 3'h0, f[0] | f[2]}, 8'h0,
        {1'h0, tCnt}, cq(q), 8'h0, 8'h0, 8'h0, 8'h0, 8'h0, 8'h0, 8'h0};
    end else begin
      eCnt = (eCnt == COUNT_WRAP) ? 7'h0 : eCnt + 7'h1;
      b = '{{2'h0, devAddr, 2'h0, f[1], f[0] | f[2]},
        (p > PROF_MAX) ? 8'h0 : {1'h0, p}, {1'h0, eCnt}, cq(q), cq(v), cq(o),
        {1'h0, x[13:7]}, {1'h0, x[6:0]}, {1'h0, z[13:7]}, {1'h0, z[6:0]},
        8'h0};
    end
    // Copy only the layout's own entries; the last three teach entries are only padding
    for (int n = 0; n < (tch ? 8 : 11); n++) begin
      expB[n + (tch ? 17 : 1)] = b[n];
    end
    for (int n = s - 7 - 3 * !tch; n < s; n++) expB[s] ^= expB[n];
    @(posedge clk);
    @(negedge clk);
    chk(frameImage_ff, img());
    chk(192'(teachActive_ff), 192'(tch));
  endtask : fire
  // ==========================================================================
  // Main sequence
  initial begin
    logic [6:0] pc [5];
    logic [6:0] qc [5];
    logic [191:0] ex;
    pc = '{7'h00, 7'h01, 7'h20, 7'h21, 7'h7F};
    qc = '{7'h00, 7'h64, 7'h65, 7'h7F, 7'h32};
    seed = 68;
    {errors, checks, eCnt, tCnt, devAddr, tShow} = '0;
    {evalDone, evalFault, evalNoMatch, evalProfile, evalQualGood} = '0;
    {evalQualVar, evalQualOut, evalXDev, evalZDev, teachDone} = '0;
    {teachFault, teachQuality, sysFault, s_axi_awaddr, s_axi_awvalid} = '0;
    {s_axi_wdata, s_axi_wvalid, s_axi_bready, s_axi_araddr} = '0;
    {s_axi_arvalid, s_axi_rready} = '0;
    s_axi_wstrb = 4'hF;
    rst = 1'h1;
    repeat (20) @(posedge clk);
    rst <= 1'h0;
    @(negedge clk);
    chk(frameImage_ff, '0);
    axr(STAT_OFS, rd, RESP_OKAY);
    chk(192'(rd), '0);
    $display("test reset done");
    devAddr = 2'h2;
    axw(CTRL_OFS, 32'h0000_0002, RESP_OKAY);
    axw(MASK_OFS, 32'h0000_0001, RESP_OKAY);
    // Lane 0 disabled: answered OKAY, mask must keep its value
    s_axi_wstrb <= 4'h0;
    axw(MASK_OFS, 32'h0000_0006, RESP_OKAY);
    s_axi_wstrb <= 4'hF;
    axw(IMG_OFS, 32'h0000_0001, RESP_SLVERR);
    axr(8'h30, rd, RESP_SLVERR);
    chk(192'(rd), '0);
    axr(MASK_OFS, rd, RESP_OKAY);
    chk(192'(rd), 192'(1));
    $display("test registers done");
    for (int i = 0; i < 70; i++) begin
      fire(1'h0, (i < 5) ? pc[i] : 7'($random(seed)), qc[i % 5]);
    end
    chk(192'(irq_ff), 192'(1));
    axw(STAT_OFS, 32'h0000_0007, RESP_OKAY);
    @(negedge clk);
    chk(192'(irq_ff), '0);
    $display("test evaluation done");
    for (int i = 0; i < 10; i++) begin
      fire(1'h1, 7'h00, qc[i % 5]);
    end
    chk(192'(irq_ff), '0);
    repeat (5) @(posedge clk);
    @(negedge clk);
    chk(snapImage_ff, img());
    fire(1'h0, 7'h05, 7'h10);
    // Image word 2 holds bytes 9 to 12, byte 9 in the low lane
    ex = img();
    axr(IMG_OFS + 8'h08, rd, RESP_OKAY);
    chk(192'(rd), 192'(ex[95:64]));
    $display("test teach done");
    close_out();
  end
endmodule : tb_top
`default_nettype wire
